// file: dv/baud_rate_generator_bench.sv
// bench for the rate timer: registers, tick periods in every mode, restart on write
`timescale 1ns/1ns
module baud_rate_generator_bench;
    import brg_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hready, busy, rx_idle_in, s, w, h;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, rd, seed, r;
    logic        hreadyout, hresp, bit_tick, sample_tick, sync_mode, wide_mode;
    logic [19:0] gap, samples;
    logic [7:0]  lo, hi;
    int          err_total, checks_done, k;
    assign hready = hreadyout;
    brg_rate_gen dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .rx_idle_in(rx_idle_in),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .bit_tick(bit_tick),
        .sample_tick(sample_tick), .sync_mode(sync_mode), .wide_mode(wide_mode));
    brg_tick_sink sink (.hclk(hclk), .hresetn(hresetn), .bit_tick(bit_tick), .sample_tick(sample_tick),
        .busy(busy), .rx_idle_in(rx_idle_in), .gap(gap), .samples(samples));
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // multiplier picked by the mode bits; high divisor byte only counts when wide
    function automatic int period(logic ps, logic pw, logic ph, logic [7:0] ph8, logic [7:0] pl8);
        return (ps ? DIV_FAST : pw ? (ph ? DIV_FAST : DIV_ASYNC_MID) : (ph ? DIV_ASYNC_MID : DIV_ASYNC_SLOW))
            * ((pw ? {ph8, pl8} : {8'h00, pl8}) + 1);
    endfunction
    task automatic complete_run();
        if (err_total == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic step();
        @(posedge hclk);
        for (k = 0; hready !== 1'b1 && k < 100; k++) @(posedge hclk);
        if (k >= 100) begin
            err_total++;
            complete_run();
        end
    endtask
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        step();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        step();
        rd = hrdata;
    endtask
    task automatic wait_tick();
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (bit_tick !== 1'b1 && k < 20000);
        if (k >= 20000) begin
            err_total++;
            complete_run();
        end
    endtask
    initial begin
        {hsel, haddr, htrans, hwrite, hwdata, busy, hresetn} = '0;
        hsize = 3'b010;
        seed = 32'h4492;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk("wide_mode", {31'h0, wide_mode}, 32'h0);
        // divisor 0 holds the count at 0, so the status word reads 0 too
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, 12'(i * 4), 32'h0);
            chk("reset_read", rd, (i == 2) ? 32'h40 : 32'h0);
        end
        bus(1'b1, OFS_BAUD_CTL, 32'hFF);
        bus(1'b1, OFS_TX_CTL, 32'hFF);
        busy <= 1'b1;
        bus(1'b0, OFS_TX_CTL, 32'h0);
        chk("tx_ctl", rd, {24'h0, MASK_TX_CTL});
        bus(1'b0, OFS_BAUD_CTL, 32'h0);
        chk("baud_ctl", rd, {24'h0, MASK_BAUD_CTL});
        busy <= 1'b0;
        // every combination of sync, wide and high speed, random divisor
        for (int m = 0; m < 8; m++) begin
            {s, w, h} = 3'(m);
            r = xs();
            lo = {5'h0, r[2:0]};
            hi = {7'h0, r[3]};
            bus(1'b1, OFS_TX_CTL, (32'(s) << BIT_SYNC) | (32'(h) << BIT_HIGH));
            bus(1'b1, OFS_BAUD_CTL, 32'(w) << BIT_WIDE);
            bus(1'b1, OFS_DIV_HIGH, {24'h0, hi});
            bus(1'b1, OFS_DIV_LOW, {24'h0, lo});
            chk("mode", {30'h0, sync_mode, wide_mode}, {30'h0, s, w});
            repeat (3) wait_tick();
            @(posedge hclk);
            chk("bit_period", {12'h0, gap}, period(s, w, h, hi, lo));
            chk("samples", {12'h0, samples}, {24'h0, lo} + 32'h1 + (w ? {16'h0, hi, 8'h0} : 32'h0));
        end
        // a long period cut short by a new divisor must not run to the old overflow
        bus(1'b1, OFS_TX_CTL, 32'h0);
        bus(1'b1, OFS_BAUD_CTL, 32'h0);
        bus(1'b1, OFS_DIV_LOW, 32'hFF);
        repeat (100) @(posedge hclk);
        bus(1'b1, OFS_DIV_LOW, 32'h2);
        wait_tick();
        chk("restart", 32'(k), 32'(DIV_ASYNC_SLOW * 3 + 1));
        complete_run();
    end
endmodule

// file: dv/brg_tick_sink.sv
// bit timing consumer model: measures tick spacing and reports receive idle
`timescale 1ns/1ns
module brg_tick_sink (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        bit_tick,
    input  wire logic        sample_tick,
    input  wire logic        busy,
    output logic             rx_idle_in,
    output logic [19:0]      gap,
    output logic [19:0]      samples
);
    logic [19:0] cnt_q;
    logic [19:0] sc_q;
    // idle only while no frame is being received, so clock changes are safe
    assign rx_idle_in = !busy;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 20'h0;
            sc_q <= 20'h0;
            gap <= 20'h0;
            samples <= 20'h0;
        end else if (bit_tick) begin
            gap <= cnt_q + 20'h1;
            samples <= sc_q + 20'(sample_tick);
            cnt_q <= 20'h0;
            sc_q <= 20'h0;
        end else begin
            cnt_q <= cnt_q + 20'h1;
            sc_q <= sc_q + 20'(sample_tick);
        end
    end
endmodule

// file: src/brg_pkg.sv
// package for the rate timer: offsets, fields, resets, divide ratios
package brg_pkg;
    localparam logic [11:0] OFS_DIV_LOW  = 12'h000;
    localparam logic [11:0] OFS_DIV_HIGH = 12'h004;
    localparam logic [11:0] OFS_BAUD_CTL = 12'h008;
    localparam logic [11:0] OFS_TX_CTL   = 12'h00C;
    localparam logic [11:0] OFS_STATUS   = 12'h010;
    localparam int          BIT_WIDE     = 3;   // wide_divider_select in baud_control
    localparam int          BIT_IDLE     = 6;   // receive_idle_flag in baud_control
    localparam int          BIT_SYNC     = 4;   // synchronous select in transmit_status_control
    localparam int          BIT_HIGH     = 2;   // high_speed_select in transmit_status_control
    localparam logic [7:0]  RST_BAUD_CTL = 8'h00;
    localparam logic [7:0]  RST_TX_CTL   = 8'h00;
    localparam logic [7:0]  RST_DIV      = 8'h00;
    localparam logic [7:0]  MASK_BAUD_CTL = 8'h0B;
    localparam logic [7:0]  MASK_TX_CTL   = 8'hFD;
    localparam int          DIV_ASYNC_SLOW = 64;
    localparam int          DIV_ASYNC_MID  = 16;
    localparam int          DIV_FAST       = 4;
    localparam int          PRE_W          = 6;

    typedef struct packed {
        logic        sync;
        logic        wide;
        logic        high;
    } brg_mode_s;
endpackage

// file: src/brg_rate_gen.sv
// rate timer with ahb-lite register slave
//
// How it works
// RULE1: one timer, 8 or 16 bit, both modes
// RULE2: 8-bit after reset; wide select gives 16
// RULE3: free running; period from divisor pair n
// RULE4: async multiplier from high speed and wide
// RULE5: sync mode ignores high speed select
// RULE6: async 8-bit normal: fosc/(64(n+1))
// RULE7: async 16-bit normal: fosc/(16(n+1))
// RULE8: sync 8-bit: fosc/(4(n+1))
// RULE9: other modes divide by 16 or 4
// RULE10: divisor write clears timer immediately
// RULE11: software checks receive idle before clock change
// RULE12: software picks high speed or wide for accuracy
`timescale 1ns/1ns
module brg_rate_gen
    import brg_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    input  wire logic        rx_idle_in,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             bit_tick,
    output logic             sample_tick,
    output logic             sync_mode,
    output logic             wide_mode
);
    logic [7:0]  div_low_q;
    logic [7:0]  div_high_q;
    logic [7:0]  baud_ctl_q;
    logic [7:0]  tx_ctl_q;
    logic [15:0] cnt_q;
    logic [PRE_W-1:0] pre_q;
    logic        wr_pend_q;
    logic [11:0] wr_addr_q;
    logic [31:0] hrdata_q;
    logic        bit_tick_q;
    logic        sample_tick_q;
    logic        idle_s1_q;
    logic        idle_s2_q;

    // async input of the receiver: two stages before use
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idle_s1_q <= 1'b0;
            idle_s2_q <= 1'b0;
        end else begin
            idle_s1_q <= rx_idle_in;
            idle_s2_q <= idle_s1_q;
        end
    end

    // bus decode
    wire        acc_take = hsel & hready & htrans[1];
    wire        wr_take  = acc_take & hwrite;
    wire        rd_take  = acc_take & ~hwrite;
    wire        wr_low   = wr_pend_q & (wr_addr_q == OFS_DIV_LOW);
    wire        wr_high  = wr_pend_q & (wr_addr_q == OFS_DIV_HIGH);
    wire        wr_baud  = wr_pend_q & (wr_addr_q == OFS_BAUD_CTL);
    wire        wr_tx    = wr_pend_q & (wr_addr_q == OFS_TX_CTL);
    wire        div_wr   = wr_low | wr_high;

    brg_mode_s  mode;
    assign mode.sync = tx_ctl_q[BIT_SYNC];
    assign mode.wide = baud_ctl_q[BIT_WIDE];                           // RULE2
    assign mode.high = tx_ctl_q[BIT_HIGH];

    // 8-bit mode uses only the low divisor
    wire [15:0] n_val = mode.wide ? {div_high_q, div_low_q} : {8'h00, div_low_q}; // RULE1 RULE3

    // prescale: 64, 16 or 4 system clocks per timer step
    function automatic logic [PRE_W-1:0] pre_last(input brg_mode_s m);
        if (m.sync) begin
            pre_last = PRE_W'(DIV_FAST - 1);                            // RULE5 RULE8 RULE9
        end else if (m.wide & m.high) begin
            pre_last = PRE_W'(DIV_FAST - 1);                            // RULE9
        end else if (m.wide | m.high) begin
            pre_last = PRE_W'(DIV_ASYNC_MID - 1);                       // RULE7 RULE9
        end else begin
            pre_last = PRE_W'(DIV_ASYNC_SLOW - 1);                      // RULE4 RULE6
        end
    endfunction

    wire [PRE_W-1:0] pre_top = pre_last(mode);
    wire             pre_end = (pre_q >= pre_top);
    wire             cnt_end = (cnt_q >= n_val);
    wire             period  = pre_end & cnt_end;
    wire [15:0]      cnt_step  = cnt_end ? 16'h0000 : cnt_q + 16'h0001;
    wire [15:0]      cnt_next  = pre_end ? cnt_step : cnt_q;
    // leaving 16-bit width drops the upper count byte, else the 8-bit timer could outrun its divisor
    wire             narrow_wr = wr_baud & ~hwdata[BIT_WIDE];

    // timer never stops; divisor write restarts it without waiting
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_q <= '0;
            cnt_q <= 16'h0000;
        end else if (div_wr) begin
            pre_q <= '0;                                                // RULE10
            cnt_q <= 16'h0000;                                          // RULE10
        end else begin
            pre_q <= pre_end ? '0 : pre_q + PRE_W'(1);
            cnt_q <= narrow_wr ? {8'h00, cnt_next[7:0]} : cnt_next;      // RULE2 RULE3
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bit_tick_q    <= 1'b0;
            sample_tick_q <= 1'b0;
        end else begin
            bit_tick_q    <= period & ~div_wr;
            sample_tick_q <= pre_end & ~div_wr;
        end
    end

    // registers; writes land in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q  <= 1'b0;
            wr_addr_q  <= 12'h000;
            div_low_q  <= RST_DIV;
            div_high_q <= RST_DIV;
            baud_ctl_q <= RST_BAUD_CTL;
            tx_ctl_q   <= RST_TX_CTL;
        end else begin
            wr_pend_q <= wr_take;
            wr_addr_q <= haddr;
            if (wr_low) begin
                div_low_q <= hwdata[7:0];
            end
            if (wr_high) begin
                div_high_q <= hwdata[7:0];
            end
            if (wr_baud) begin
                baud_ctl_q <= hwdata[7:0] & MASK_BAUD_CTL;
            end
            if (wr_tx) begin
                tx_ctl_q <= hwdata[7:0] & MASK_TX_CTL;
            end
        end
    end

    wire [7:0]  baud_rd = baud_ctl_q | {1'b0, idle_s2_q, 6'h00};
    wire [31:0] rd_mux  = (haddr == OFS_DIV_LOW)  ? {24'h000000, div_low_q} :
                          (haddr == OFS_DIV_HIGH) ? {24'h000000, div_high_q} :
                          (haddr == OFS_BAUD_CTL) ? {24'h000000, baud_rd} :
                          (haddr == OFS_TX_CTL)   ? {24'h000000, tx_ctl_q} :
                          (haddr == OFS_STATUS)   ? {16'h0000, cnt_q} :
                          32'h00000000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h00000000;
        end else if (rd_take) begin
            hrdata_q <= rd_mux;
        end
    end

    assign hrdata      = hrdata_q;
    assign hreadyout   = 1'b1;
    assign hresp       = 1'b0;
    assign bit_tick    = bit_tick_q;
    assign sample_tick = sample_tick_q;
    assign sync_mode   = tx_ctl_q[BIT_SYNC];
    assign wide_mode   = baud_ctl_q[BIT_WIDE];

    // helper: cycles between two bit ticks with no divisor/mode write
    logic [23:0] gap_q;
    logic        chg_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gap_q <= 24'h000000;
            chg_q <= 1'b1;
        end else if (bit_tick_q) begin
            gap_q <= 24'h000001;
            chg_q <= wr_pend_q;
        end else begin
            gap_q <= gap_q + 24'h000001;
            chg_q <= chg_q | wr_pend_q;
        end
    end
    wire [23:0] exp_gap = 24'({8'h00, n_val} + 24'h000001) * 24'({18'h0, pre_top} + 24'h000001);

    period_len_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE3
        (bit_tick_q && !chg_q && !wr_pend_q) |-> gap_q == exp_gap)
        else $error("tick spacing wrong");
    slow_div_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE6
        (!mode.sync && !mode.wide && !mode.high) |-> pre_top == 6'h3F)
        else $error("async 8-bit normal not 64");
    mid_div_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE7
        (!mode.sync && mode.wide && !mode.high) |-> pre_top == 6'h0F)
        else $error("async 16-bit normal not 16");
    sync_div_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE8
        mode.sync |-> pre_top == 6'h03)
        else $error("sync not 4");
    fast_div_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE9
        (!mode.sync && mode.high) |-> pre_top == (mode.wide ? 6'h03 : 6'h0F))
        else $error("high speed ratio wrong");
    sync_ignore_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE5
        (mode.sync && $changed(mode.high) && $stable(mode.sync)) |-> $stable(pre_top))
        else $error("high speed changed sync rate");
    restart_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE10
        div_wr |=> (cnt_q == 16'h0000 && pre_q == '0 && !bit_tick_q))
        else $error("divisor write did not clear timer");
    narrow_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE2
        !mode.wide |-> cnt_q[15:8] == 8'h00)
        else $error("8-bit timer exceeded");
    runs_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE1
        (!div_wr && !pre_end) |=> pre_q == $past(pre_q) + PRE_W'(1))
        else $error("timer stalled");

    // helper: cycles since the last divisor write while nothing else was written
    logic [23:0] since_q;
    logic        first_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            since_q <= 24'h000000;
            first_q <= 1'b0;
        end else if (div_wr) begin
            since_q <= 24'h000001;
            first_q <= 1'b1;
        end else begin
            since_q <= since_q + 24'h000001;
            first_q <= first_q & ~bit_tick_q & ~wr_pend_q;
        end
    end

    first_tick_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE10
        (bit_tick_q && first_q) |-> since_q == exp_gap + 24'h000001)
        else $error("first tick after divisor write mistimed");

    // writes land at the end of the data phase, reads answer in it
    low_store_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE3
        wr_low |=> div_low_q == $past(hwdata[7:0]))
        else $error("low divisor write lost");
    high_store_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE3
        wr_high |=> div_high_q == $past(hwdata[7:0]))
        else $error("high divisor write lost");
    wide_store_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE2
        wr_baud |=> mode.wide == $past(hwdata[BIT_WIDE]))
        else $error("wide select write lost");
    sync_store_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE8
        wr_tx |=> mode.sync == $past(hwdata[BIT_SYNC]))
        else $error("sync select write lost");
    speed_store_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE4
        wr_tx |=> mode.high == $past(hwdata[BIT_HIGH]))
        else $error("high speed write lost");
    low_read_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE3
        (rd_take && haddr == OFS_DIV_LOW) |=> hrdata_q == {24'h000000, $past(div_low_q)})
        else $error("low divisor read wrong");
    high_read_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE3
        (rd_take && haddr == OFS_DIV_HIGH) |=> hrdata_q == {24'h000000, $past(div_high_q)})
        else $error("high divisor read wrong");
    count_read_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE3
        (rd_take && haddr == OFS_STATUS) |=> hrdata_q == {16'h0000, $past(cnt_q)})
        else $error("count read wrong");
    idle_read_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE11
        (rd_take && haddr == OFS_BAUD_CTL) |=> hrdata_q[BIT_IDLE] == $past(idle_s2_q))
        else $error("receive idle read wrong");

    // ticks are single pulses and a bit tick always falls on a timer step
    tick_single_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE3
        bit_tick_q |=> !bit_tick_q)
        else $error("bit tick longer than one cycle");
    tick_step_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE3
        bit_tick_q |-> sample_tick_q)
        else $error("bit tick off a timer step");
    step_single_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE4
        sample_tick_q |=> !sample_tick_q)
        else $error("step tick longer than one cycle");
    restart_step_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE10
        div_wr |=> !sample_tick_q)
        else $error("step tick after divisor write");
    count_bound_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE3
        !chg_q |-> cnt_q <= n_val)
        else $error("count beyond divisor");
    pre_bound_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE4
        !chg_q |-> pre_q <= pre_top)
        else $error("prescale beyond multiplier");

    // 8-bit width bounds the period; 16-bit synchronous still divides by 4
    narrow_max_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE2
        (bit_tick_q && !chg_q && !mode.wide) |-> gap_q <= 24'(DIV_ASYNC_SLOW * 256))
        else $error("8-bit period too long");
    narrow_clear_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE2
        narrow_wr |=> cnt_q[15:8] == 8'h00)
        else $error("upper count kept in 8-bit width");
    sync_wide_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE9
        (mode.sync && mode.wide) |-> pre_top == 6'h03)
        else $error("sync 16-bit not 4");
endmodule
